// ===== mbl_pkg.sv
// Package for the bit-logic and call execution slice of the core.
// Assumes a single core clock and a decoder that presents one operation at a time.
package mbl_pkg;
    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    // Data path width.
    localparam int MBL_DATA_W = 8;
    // Program counter width.
    localparam int MBL_PC_W = 11;
    // File register address width.
    localparam int MBL_ADDR_W = 6;
    // Return stack pointer width.
    localparam int MBL_SP_W = 3;
    // Bits of the high page pointer that reach the counter.
    localparam int MBL_PAGE_W = 3;
    // ------------------------------------------------------------------
    // Operation codes
    // ------------------------------------------------------------------
    // Operation select presented by the decoder.
    localparam logic [2:0] MBL_OP_NONE = 3'h0;
    localparam logic [2:0] MBL_OP_ANDI = 3'h1;
    localparam logic [2:0] MBL_OP_SETB = 3'h2;
    localparam logic [2:0] MBL_OP_SKPC = 3'h3;
    localparam logic [2:0] MBL_OP_SKPS = 3'h4;
    localparam logic [2:0] MBL_OP_CALL = 3'h5;
    localparam logic [2:0] MBL_OP_CLEAR_ACC_OP = 3'h6;
    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    // Accumulator after reset.
    localparam logic [7:0] MBL_ACC_RST = 8'h00;
    // Program counter after reset.
    localparam logic [10:0] MBL_PC_RST = 11'h000;
    // Stack pointer after reset.
    localparam logic [2:0] MBL_SP_RST = 3'h0;
    // Execution state machine.
    typedef enum logic [1:0]
    {
        MBL_ST_RUN = 2'h0,
        MBL_ST_FLUSH = 2'h1
    } mbl_state_t;
endpackage

// ===== mbl_bitsel.sv
// Bit selector helpers: a one-hot mask and the tested bit of a byte.
// Assumes the bit number is already decoded from the instruction word.
module mbl_bitsel
    import mbl_pkg::*;
(
    // Operand byte and bit number.
    input wire logic [7:0] data,
    input wire logic [2:0] bit_num,
    // Results.
    output logic [7:0] mask,
    output logic bit_val
);
    // Mask with only the selected bit high.
    assign mask = 8'h01 << bit_num;
    // Selected bit of the operand.
    assign bit_val = data[bit_num];
endmodule

// ===== mbl_exec.sv
// Execution slice for immediate AND, bit set, bit test and skip,
// indirect call and accumulator clear.
// Assumes the register file returns read data for the presented address
// combinationally and that the return stack writes on the push strobe.
//
// Functional notes
// - AND immediate into accumulator, Z only.
// - Set one register bit, flags untouched.
// - Skip next instruction when bit clear.
// - Skip next instruction when bit set.
// - Call pushes PC plus one, two cycles.
// - Call loads PC from page and accumulator.
// - Clear accumulator and set zero flag.
module mbl_exec
    import mbl_pkg::*;
(
    // Clock and reset.
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    // Decoded instruction.
    input wire logic OP_VALID,
    input wire logic [2:0] OP_SEL,
    input wire logic [7:0] OP_IMM,
    input wire logic [5:0] OP_ADDR,
    input wire logic [2:0] OP_BIT,
    // Register file read data and page pointer.
    input wire logic [7:0] REG_RDATA,
    input wire logic [7:0] HIGH_PAGE_POINTER,
    // Register file write port.
    output logic REG_WE,
    output logic [5:0] REG_WADDR,
    output logic [7:0] REG_WDATA,
    // Core state.
    output logic [7:0] ACCUMULATOR,
    output logic ZERO_FLAG,
    output logic [10:0] PC,
    // Return stack push port.
    output logic STACK_PUSH,
    output logic [2:0] STACK_PTR,
    output logic [10:0] STACK_WDATA,
    // High while the fetched instruction is being squashed.
    output logic SQUASH
);
    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    // Execution state.
    mbl_state_t state;
    mbl_state_t next_state;
    // Mask and tested bit from the selector.
    logic [7:0] bit_mask;
    logic bit_val;
    // An operation is accepted only in the run state.
    wire take = OP_VALID && (state == MBL_ST_RUN);
    wire is_andi = take && (OP_SEL == MBL_OP_ANDI);
    wire is_setb = take && (OP_SEL == MBL_OP_SETB);
    wire is_skpc = take && (OP_SEL == MBL_OP_SKPC);
    wire is_skps = take && (OP_SEL == MBL_OP_SKPS);
    wire is_call = take && (OP_SEL == MBL_OP_CALL);
    wire is_clear_acc_op = take && (OP_SEL == MBL_OP_CLEAR_ACC_OP);
    wire do_skip = (is_skpc && !bit_val) || (is_skps && bit_val);
    wire [7:0] and_res = ACCUMULATOR & OP_IMM;
    // Call target from page and accumulator.
    wire [10:0] call_tgt = {HIGH_PAGE_POINTER[2:0], ACCUMULATOR};
    wire [10:0] ret_addr = PC + 11'h001;

    // Bit selector on the register read data.
    mbl_bitsel u_bitsel
    (
        .data(REG_RDATA),
        .bit_num(OP_BIT),
        .mask(bit_mask),
        .bit_val(bit_val)
    );

    // ------------------------------------------------------------------
    // State machine
    // ------------------------------------------------------------------
    // Calls and taken skips spend one extra cycle squashing.
    always_comb
    begin
        case (state)
            MBL_ST_RUN: next_state = (do_skip || is_call) ? MBL_ST_FLUSH : MBL_ST_RUN;
            MBL_ST_FLUSH: next_state = MBL_ST_RUN;
            default: next_state = MBL_ST_RUN;
        endcase
    end

    // State register.
    always_ff @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            state <= MBL_ST_RUN;
        else
            state <= next_state;
    end

    // ------------------------------------------------------------------
    // Accumulator and flag
    // ------------------------------------------------------------------
    // Accumulator and zero flag updates; other operations hold both.
    always_ff @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            ACCUMULATOR <= MBL_ACC_RST;
            ZERO_FLAG <= 1'b0;
        end
        else if (is_andi)
        begin
            ACCUMULATOR <= and_res;
            ZERO_FLAG <= (and_res == 8'h00);
        end
        else if (is_clear_acc_op)
        begin
            ACCUMULATOR <= 8'h00;
            ZERO_FLAG <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Register write
    // ------------------------------------------------------------------
    // Bit set writes back one cycle later.
    always_ff @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            REG_WE <= 1'b0;
            REG_WADDR <= 6'h00;
            REG_WDATA <= 8'h00;
        end
        else
        begin
            REG_WE <= is_setb;
            REG_WADDR <= OP_ADDR;
            REG_WDATA <= REG_RDATA | bit_mask;
        end
    end

    // ------------------------------------------------------------------
    // Program counter, stack and squash
    // ------------------------------------------------------------------
    // PC advances per accepted operation and per squash cycle; a call jumps.
    always_ff @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            PC <= MBL_PC_RST;
            STACK_PTR <= MBL_SP_RST;
            STACK_PUSH <= 1'b0;
            STACK_WDATA <= 11'h000;
            SQUASH <= 1'b0;
        end
        else
        begin
            STACK_PUSH <= is_call;
            SQUASH <= do_skip || is_call;
            if (is_call)
            begin
                PC <= call_tgt;
                STACK_WDATA <= ret_addr;
                STACK_PTR <= STACK_PTR + 3'h1;
            end
            else if (take || state == MBL_ST_FLUSH)
                PC <= ret_addr;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    and_imm_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        is_andi |=> (ACCUMULATOR == ($past(ACCUMULATOR) & $past(OP_IMM))) && !SQUASH)
        else $error("AND immediate result wrong.");
    set_bit_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        is_setb |=> REG_WE && REG_WDATA[$past(OP_BIT)] && $stable(ZERO_FLAG))
        else $error("Bit set write wrong.");
    skip_clear_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        (is_skpc && !bit_val) |=> SQUASH && state == MBL_ST_FLUSH ##1 state == MBL_ST_RUN)
        else $error("Clear skip not taken.");
    skip_set_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        is_skps |=> (SQUASH == $past(bit_val)))
        else $error("Set skip wrong.");
    call_push_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        is_call |=> STACK_PUSH && STACK_WDATA == $past(PC) + 11'h001 ##1 state == MBL_ST_RUN)
        else $error("Call push wrong.");
    call_target_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        is_call |=> PC == {$past(HIGH_PAGE_POINTER[2:0]), $past(ACCUMULATOR)})
        else $error("Call target wrong.");
    clear_acc_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        is_clear_acc_op |=> ACCUMULATOR == 8'h00 && ZERO_FLAG)
        else $error("Accumulator clear wrong.");
    stack_step_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        is_call |=> STACK_PTR == $past(STACK_PTR) + 3'h1)
        else $error("Stack pointer did not step.");
endmodule

// ===== mcu_bit_logic_call_ops_test.sv
// Self-checking bench for the bit-logic and call execution slice.
// Assumes mbl_pkg and mbl_exec are compiled first; inputs change on falling edges.
module mcu_bit_logic_call_ops_test
    import mbl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------
    // Signals and table
    // ------------------------------------------------------------------
    // Bench-side copies of every port.
    logic ref_clk, sys_rst, op_valid, reg_we, zero_flag, stack_push, squash;
    logic [2:0] op_sel, op_bit, stack_ptr, sp0;
    logic [7:0] op_imm, reg_rdata, page, reg_wdata, acc, acc0;
    logic [5:0] op_addr, reg_waddr;
    logic [10:0] pc, stack_wdata, pc0;
    logic z0;
    int n_errors = 0;
    int n_checks = 0;
    // One row: operation, operands, and the write and squash it must give.
    typedef struct packed {logic [2:0] sel; logic [5:0] addr; logic [2:0] bnum;
        logic [7:0] rdata; logic we; logic [7:0] wdata; logic sq;} mbl_row_t;
    localparam mbl_row_t ROWS[11] = '{
        '{MBL_OP_SETB, 6'h00, 3'h0, 8'h00, 1'h1, 8'h01, 1'h0},
        '{MBL_OP_SETB, 6'h3F, 3'h1, 8'hFF, 1'h1, 8'hFF, 1'h0},
        '{MBL_OP_SETB, 6'h15, 3'h2, 8'h5A, 1'h1, 8'h5E, 1'h0},
        '{MBL_OP_SETB, 6'h2A, 3'h3, 8'h00, 1'h1, 8'h08, 1'h0},
        '{MBL_OP_SETB, 6'h01, 3'h4, 8'h0F, 1'h1, 8'h1F, 1'h0},
        '{MBL_OP_SETB, 6'h3E, 3'h5, 8'hC0, 1'h1, 8'hE0, 1'h0},
        '{MBL_OP_SETB, 6'h20, 3'h6, 8'h00, 1'h1, 8'h40, 1'h0},
        '{MBL_OP_SETB, 6'h10, 3'h7, 8'h7F, 1'h1, 8'hFF, 1'h0},
        '{MBL_OP_SKPC, 6'h05, 3'h3, 8'h5A, 1'h0, 8'h00, 1'h0},
        '{MBL_OP_SKPS, 6'h05, 3'h2, 8'h5A, 1'h0, 8'h00, 1'h0},
        '{MBL_OP_ANDI, 6'h00, 3'h0, 8'hAF, 1'h0, 8'h00, 1'h0}};
    mbl_exec mbl_exec_i (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .OP_VALID(op_valid),
        .OP_SEL(op_sel), .OP_IMM(op_imm), .OP_ADDR(op_addr), .OP_BIT(op_bit),
        .REG_RDATA(reg_rdata), .HIGH_PAGE_POINTER(page), .REG_WE(reg_we),
        .REG_WADDR(reg_waddr), .REG_WDATA(reg_wdata), .ACCUMULATOR(acc),
        .ZERO_FLAG(zero_flag), .PC(pc), .STACK_PUSH(stack_push), .STACK_PTR(stack_ptr),
        .STACK_WDATA(stack_wdata), .SQUASH(squash));
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    // Prints the verdict and stops the run.
    task automatic end_sim();
        if (n_errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Compares a value with case inequality so unknowns never match.
    task automatic chk_word(input string nm, input logic [10:0] e, input logic [10:0] g);
        n_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Byte and flag compares widen to the word form.
    task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
        chk_word(nm, {3'h0, e}, {3'h0, g});
    endtask
    task automatic chk_bit(input string nm, input logic e, input logic g);
        chk_word(nm, {10'h000, e}, {10'h000, g});
    endtask
    // Presents one operation for one cycle and notes the state before it.
    task automatic apply(input logic [2:0] sel, input logic [5:0] a, input logic [2:0] b,
        input logic [7:0] d);
        op_valid = 1'h1;
        op_sel = sel;
        op_addr = a;
        op_bit = b;
        op_imm = d;
        reg_rdata = d;
        {pc0, z0, acc0, sp0} = {pc, zero_flag, acc, stack_ptr};
        @(negedge ref_clk);
    endtask
    // PC, accumulator, stack pointer, zero flag and strobes must read zero while and right after reset.
    task automatic chk_rst();
        chk_word("PC", 11'h000, pc);
        chk_byte("ACCUMULATOR", 8'h00, acc);
        chk_word("STACK_PTR", 11'h000, {8'h00, stack_ptr});
        chk_bit("ZERO_FLAG", 1'h0, zero_flag);
        chk_word("STROBES", 11'h000, {8'h00, reg_we, stack_push, squash});
    endtask
    // ------------------------------------------------------------------
    // Clock, watchdog and sequence
    // ------------------------------------------------------------------
    // Core clock at 25 MHz.
    initial
    begin
        ref_clk = 1'h0;
        forever #20 ref_clk = ~ref_clk;
    end
    // The tests need under 100 cycles; 2500 cycles means a hang.
    initial
    begin
        #100000;
        n_errors++;
        end_sim();
    end
    // Main sequence: reset, table, then skip, call and reset cases.
    initial
    begin
        // Reset is raised at time zero; every other input starts at zero.
        {op_valid, op_sel, op_imm, op_addr, op_bit, reg_rdata} = 29'h0000000;
        sys_rst = 1'h1;
        page = 8'h00;
        repeat (16) @(negedge ref_clk);
        sys_rst = 1'h0;
        chk_rst();
        apply(MBL_OP_CLEAR_ACC_OP, 6'h00, 3'h0, 8'h00);
        chk_bit("ZERO_FLAG", 1'h1, zero_flag);
        chk_byte("ACCUMULATOR", 8'h00, acc);
        foreach (ROWS[i])
        begin
            apply(ROWS[i].sel, ROWS[i].addr, ROWS[i].bnum, ROWS[i].rdata);
            chk_bit("REG_WE", ROWS[i].we, reg_we);
            if (ROWS[i].we)
            begin
                chk_word("REG_WADDR", {5'h00, ROWS[i].addr}, {5'h00, reg_waddr});
                chk_byte("REG_WDATA", ROWS[i].wdata, reg_wdata);
            end
            chk_bit("SQUASH", ROWS[i].sq, squash);
            chk_word("PC", pc0 + 11'h001, pc);
            chk_bit("ZERO_FLAG", (ROWS[i].sel == MBL_OP_ANDI) | z0, zero_flag);
        end
        // Taken skips and calls; the op in the squash slot must be ignored.
        for (int k = 0; k < 4; k++)
        begin
            page = k[0] ? 8'h02 : 8'hFD;
            if (k < 2)
                apply(k[0] ? MBL_OP_SKPS : MBL_OP_SKPC, 6'h05, k[0] ? 3'h3 : 3'h2, 8'h5A);
            else
                apply(MBL_OP_CALL, 6'h00, 3'h0, 8'h00);
            chk_bit("SQUASH", 1'h1, squash);
            if (k < 2)
                chk_word("PC", pc0 + 11'h001, pc);
            else
            begin
                chk_word("PC", {page[2:0], acc0}, pc);
                chk_word("STACK_WDATA", pc0 + 11'h001, stack_wdata);
                chk_word("STACK_PTR", {8'h00, sp0 + 3'h1}, {8'h00, stack_ptr});
                chk_bit("STACK_PUSH", 1'h1, stack_push);
            end
            apply(MBL_OP_SETB, 6'h07, 3'h0, 8'h00);
            chk_word("SLOT_PC", pc0 + 11'h001, pc);
            chk_word("SLOT_STROBES", 11'h000, {8'h00, reg_we, stack_push, squash});
        end
        // Reset in mid-run, then AND must set the zero flag from zero.
        sys_rst = 1'h1;
        @(negedge ref_clk);
        chk_rst();
        sys_rst = 1'h0;
        apply(MBL_OP_ANDI, 6'h00, 3'h0, 8'hFF);
        chk_word("ANDI", {3'h2, 8'h00}, {1'h0, zero_flag, reg_we, acc});
        end_sim();
    end
endmodule
